/* File: core/drive_homing_consts.vh */
`ifndef DRIVE_HOMING_CONSTS_VH
`define DRIVE_HOMING_CONSTS_VH

// ----------------------------------------
// parameter addresses
// ----------------------------------------
`define ADDR_POWER_ON_POLICY   16'h050c
`define ADDR_IO_CHANNEL1_FUNC  16'h0722
`define ADDR_DIRECT_OUTPUT     16'h0822
`define ADDR_HOME_POSITION     16'h2816
`define ADDR_SEARCH_LIMIT      16'h281a
`define ADDR_STATUS            16'h2900
`define ADDR_CURRENT_POSITION  16'h2902
`define ADDR_POSITION_SET      16'h2904

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_POWER_ON_POLICY    16'h0000
`define RST_IO_CHANNEL1_FUNC   16'h0001
`define RST_DIRECT_OUTPUT      16'h0000
`define RST_HOME_POSITION      32'h0000_0000
`define RST_SEARCH_LIMIT       32'h0000_0000

// ----------------------------------------
// power-on enable policies
// ----------------------------------------
`define POLICY_EDGE            16'h0000
`define POLICY_LEVEL           16'h0001
`define POLICY_AUTO            16'h0002

// ----------------------------------------
// io function codes
// ----------------------------------------
`define FN_IN_FREE             16'h0001
`define FN_IN_FAULT_RESET      16'h0002
`define FN_IN_ENABLE           16'h0003
`define FN_IN_HALT             16'h0004
`define FN_IN_JOG_POS          16'h0009
`define FN_IN_JOG_NEG          16'h000a
`define FN_IN_JOG_FAST         16'h000b
`define FN_IN_REF_SWITCH       16'h0014
`define FN_IN_LIMIT_POS        16'h0015
`define FN_OUT_FREE            16'h0065
`define FN_OUT_NO_FAULT        16'h0066
`define FN_OUT_READY           16'h0067

// ----------------------------------------
// status word fields
// ----------------------------------------
`define ST_STAGE_ON            0
`define ST_SEARCH_ERROR        1
`define ST_SEARCH_ACTIVE       2

`endif

/* File: core/drive_homing_io.v */
`timescale 1ns/1ps
`include "drive_homing_consts.vh"

module drive_homing_io (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // parameter access port
  input  wire [15:0] par_addr,
  input  wire [31:0] par_wdata,
  input  wire        par_wr,
  input  wire        par_rd,
  output reg  [31:0] par_rdata,
  output reg         par_ack,
  output reg         par_err,
  // motion logic
  input  wire        motor_standstill,
  input  wire        motor_start,
  input  wire        step_pulse,
  input  wire        step_dir_neg,
  input  wire        homing_success,
  input  wire        overtravel_seen,
  input  wire        switch_seen_again,
  output reg  [31:0] current_position,
  output reg         homing_cancel,
  output reg         search_error,
  // drive state
  input  wire        local_mode,
  input  wire        fault_present,
  input  wire        drive_ready,
  input  wire        stage_disable_req,
  output reg         power_stage_on,
  // configurable io one pin
  input  wire        configurable_io_one_in,
  output reg         configurable_io_one_out,
  output reg         configurable_io_one_oe_n,
  // decoded io functions
  output reg         fault_reset_req,
  output reg         halt_req,
  output reg         jog_pos,
  output reg         jog_neg,
  output reg         jog_fast,
  output reg         ref_switch,
  output reg         positive_travel_limit,
  // digital outputs
  output reg  [15:0] digital_out
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function is_output_fn;
    input [15:0] fn;
    begin
      is_output_fn = (fn == `FN_OUT_FREE) || (fn == `FN_OUT_NO_FAULT) || (fn == `FN_OUT_READY);
    end
  endfunction

  function valid_fn;
    input [15:0] fn;
    begin
      valid_fn = is_output_fn(fn) || (fn == `FN_IN_FREE) || (fn == `FN_IN_FAULT_RESET) ||
                 (fn == `FN_IN_ENABLE) || (fn == `FN_IN_HALT) || (fn == `FN_IN_JOG_POS) ||
                 (fn == `FN_IN_JOG_NEG) || (fn == `FN_IN_JOG_FAST) ||
                 (fn == `FN_IN_REF_SWITCH) || (fn == `FN_IN_LIMIT_POS);
    end
  endfunction

  // ----------------------------------------
  // stored parameters and state
  // ----------------------------------------
  reg [15:0] power_on_enable_policy;
  reg [15:0] io_channel1_function = `RST_IO_CHANNEL1_FUNC;
  reg [15:0] direct_output_word;
  reg [31:0] home_position_value;
  reg [31:0] overtravel_search_limit;
  reg [31:0] position_set_command;
  reg [31:0] active_home;
  reg [31:0] active_limit;
  reg [15:0] active_policy;
  reg [15:0] active_fn;
  reg        fn_loaded;
  reg        search_active;
  reg [31:0] search_count;
  reg        sync1;
  reg        sync2;
  reg        sync3;
  reg        io_level;
  reg        enable_prev;

  wire par_access   = par_wr | par_rd;
  wire wr_policy    = par_wr && (par_addr == `ADDR_POWER_ON_POLICY);
  wire wr_fn        = par_wr && (par_addr == `ADDR_IO_CHANNEL1_FUNC);
  wire wr_out       = par_wr && (par_addr == `ADDR_DIRECT_OUTPUT);
  wire wr_home      = par_wr && (par_addr == `ADDR_HOME_POSITION);
  wire wr_limit     = par_wr && (par_addr == `ADDR_SEARCH_LIMIT);
  wire wr_status    = par_wr && (par_addr == `ADDR_STATUS);
  wire wr_setpos    = par_wr && (par_addr == `ADDR_POSITION_SET);
  wire fn_refused   = wr_fn && (power_stage_on || !valid_fn(par_wdata[15:0]));
  wire set_refused  = wr_setpos && !motor_standstill;
  wire enable_in    = (active_fn == `FN_IN_ENABLE) && local_mode && io_level;
  wire search_trip  = search_active && !switch_seen_again && (search_count >= active_limit);

  reg        next_known;
  reg [31:0] next_rdata;

  // ----------------------------------------
  // parameter read decode
  // ----------------------------------------
  always @* begin
    next_known = 1'b1;
    next_rdata = 32'h0000_0000;
    case (par_addr)
      `ADDR_POWER_ON_POLICY:  next_rdata = {16'h0000, power_on_enable_policy};
      `ADDR_IO_CHANNEL1_FUNC: next_rdata = {16'h0000, io_channel1_function};
      `ADDR_DIRECT_OUTPUT:    next_rdata = {16'h0000, direct_output_word};
      `ADDR_HOME_POSITION:    next_rdata = home_position_value;
      `ADDR_SEARCH_LIMIT:     next_rdata = overtravel_search_limit;
      `ADDR_STATUS:           next_rdata = {29'h0, search_active, search_error, power_stage_on};
      `ADDR_CURRENT_POSITION: next_rdata = current_position;
      `ADDR_POSITION_SET:     next_rdata = position_set_command;
      default:                next_known = 1'b0;
    endcase
  end

  // ----------------------------------------
  // parameter writes and answer
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_on_enable_policy  <= `RST_POWER_ON_POLICY;
      direct_output_word      <= `RST_DIRECT_OUTPUT;
      home_position_value     <= `RST_HOME_POSITION;
      overtravel_search_limit <= `RST_SEARCH_LIMIT;
      position_set_command    <= 32'h0000_0000;
      par_ack                 <= 1'b0;
      par_err                 <= 1'b0;
      par_rdata               <= 32'h0000_0000;
      digital_out             <= 16'h0000;
    end else begin
      par_ack   <= par_access;
      par_err   <= par_access && (!next_known || fn_refused || set_refused || (par_wr && par_addr ==
                   `ADDR_CURRENT_POSITION));
      par_rdata <= (par_rd && next_known) ? next_rdata : 32'h0000_0000;
      if (wr_policy)
        power_on_enable_policy <= par_wdata[15:0];
      if (wr_out)
        direct_output_word <= par_wdata[15:0];
      if (wr_home)
        home_position_value <= par_wdata;
      if (wr_limit)
        overtravel_search_limit <= par_wdata;
      if (wr_setpos)
        position_set_command <= par_wdata;
      digital_out <= direct_output_word;
    end
  end

  // stored function keeps its value through reset_n, otherwise a code written
  // before a power-on could never be the one latched after it
  always @(posedge clk_sys) begin
    if (wr_fn && !fn_refused)
      io_channel1_function <= par_wdata[15:0];
  end

  // ----------------------------------------
  // position, homing shadows, search monitor
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      current_position <= 32'h0000_0000;
      active_home      <= `RST_HOME_POSITION;
      active_limit     <= `RST_SEARCH_LIMIT;
      search_active    <= 1'b0;
      search_count     <= 32'h0000_0000;
      homing_cancel    <= 1'b0;
      search_error     <= 1'b0;
    end else begin
      // shadows refresh only as the motor starts so a running move never sees a change
      if (motor_start) begin
        active_home  <= home_position_value;
        active_limit <= overtravel_search_limit;
      end
      // raw value, no scaling, applied in the write cycle itself
      if (wr_setpos && motor_standstill)
        current_position <= par_wdata;
      else if (homing_success)
        current_position <= active_home;
      else if (step_pulse)
        current_position <= step_dir_neg ? current_position - 32'h0000_0001 : current_position + 32'h0000_0001;
      homing_cancel <= search_trip;
      if (overtravel_seen && (active_limit != 32'h0000_0000)) begin
        search_active <= 1'b1;
        search_count  <= 32'h0000_0000;
      end else if (switch_seen_again || search_trip) begin
        search_active <= 1'b0;
      end else if (search_active && step_pulse) begin
        search_count <= search_count + 32'h0000_0001;
      end
      // hardware set wins over a clear in the same cycle
      if (search_trip)
        search_error <= 1'b1;
      else if (wr_status && par_wdata[`ST_SEARCH_ERROR])
        search_error <= 1'b0;
    end
  end

  // ----------------------------------------
  // io pin synchroniser and function latch
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      io_level  <= 1'b0;
      active_fn <= `RST_IO_CHANNEL1_FUNC;
      fn_loaded <= 1'b0;
    end else begin
      sync1 <= configurable_io_one_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        io_level <= sync3;
      // captured once after power-on; later writes wait for the next one
      if (!fn_loaded) begin
        active_fn <= io_channel1_function;
        fn_loaded <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // io function decode
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_reset_req          <= 1'b0;
      halt_req                 <= 1'b0;
      jog_pos                  <= 1'b0;
      jog_neg                  <= 1'b0;
      jog_fast                 <= 1'b0;
      ref_switch               <= 1'b0;
      positive_travel_limit    <= 1'b0;
      configurable_io_one_out  <= 1'b0;
      configurable_io_one_oe_n <= 1'b1;
    end else begin
      fault_reset_req       <= (active_fn == `FN_IN_FAULT_RESET) && local_mode && io_level;
      halt_req              <= (active_fn == `FN_IN_HALT) && io_level;
      ref_switch            <= (active_fn == `FN_IN_REF_SWITCH) && io_level;
      positive_travel_limit <= (active_fn == `FN_IN_LIMIT_POS) && io_level;
      jog_pos               <= (active_fn == `FN_IN_JOG_POS) && io_level;
      jog_neg               <= (active_fn == `FN_IN_JOG_NEG) && io_level;
      jog_fast              <= (active_fn == `FN_IN_JOG_FAST) && io_level;
      configurable_io_one_oe_n <= !is_output_fn(active_fn);
      case (active_fn)
        `FN_OUT_FREE:     configurable_io_one_out <= direct_output_word[0];
        `FN_OUT_NO_FAULT: configurable_io_one_out <= !fault_present;
        `FN_OUT_READY:    configurable_io_one_out <= drive_ready;
        default:          configurable_io_one_out <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // power stage enable
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_stage_on <= 1'b0;
      active_policy  <= `RST_POWER_ON_POLICY;
      enable_prev    <= 1'b0;
    end else begin
      enable_prev <= enable_in;
      // policy frozen while enabled, so a change only counts at the next enable
      if (!power_stage_on)
        active_policy <= power_on_enable_policy;
      if (fault_present || stage_disable_req)
        power_stage_on <= 1'b0;
      else if (!power_stage_on) begin
        case (active_policy)
          `POLICY_EDGE:  power_stage_on <= enable_in && !enable_prev;
          `POLICY_LEVEL: power_stage_on <= enable_in;
          `POLICY_AUTO:  power_stage_on <= 1'b1;
          default:       power_stage_on <= 1'b0;
        endcase
      end
    end
  end

endmodule

/* File: testbench/drive_homing_io_properties.sv */
`timescale 1ns/1ps
`include "drive_homing_consts.vh"

module drive_homing_io_properties (
  // clock and reset
  input logic        clk_sys,
  input logic        reset_n,
  // parameter access
  input logic [15:0] par_addr,
  input logic [31:0] par_wdata,
  input logic        par_wr,
  input logic        par_rd,
  input logic [31:0] par_rdata,
  input logic        par_ack,
  input logic        par_err,
  // motion and drive state
  input logic        motor_standstill,
  input logic        step_pulse,
  input logic        homing_success,
  input logic [31:0] current_position,
  input logic        homing_cancel,
  input logic        search_error,
  input logic        local_mode,
  input logic        fault_present,
  input logic        power_stage_on,
  input logic        fault_reset_req,
  input logic [15:0] digital_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_ACK: assert property ((par_wr || par_rd) |=> par_ack) else $error("no answer to access");
  AST_SET_POS: assert property (par_wr && par_addr == `ADDR_POSITION_SET && motor_standstill
    |=> current_position == $past(par_wdata)) else $error("position not set");
  AST_SET_MOVING: assert property (par_wr && par_addr == `ADDR_POSITION_SET && !motor_standstill
    && !step_pulse && !homing_success |=> par_err && $stable(current_position))
    else $error("position set while moving");
  AST_IO_REFUSE: assert property (par_wr && par_addr == `ADDR_IO_CHANNEL1_FUNC && power_stage_on
    |=> par_err) else $error("io function write not refused");
  AST_DOUT: assert property (par_wr && par_addr == `ADDR_DIRECT_OUTPUT
    |=> ##1 digital_out == $past(par_wdata[15:0], 2)) else $error("digital outputs wrong");
  AST_CANCEL_ERR: assert property (homing_cancel |-> search_error) else $error("cancel without error");
  AST_FAULT_OFF: assert property (fault_present |=> !power_stage_on) else $error("stage on during fault");
  AST_LOCAL: assert property (!local_mode && !$past(local_mode) |-> !fault_reset_req)
    else $error("fault reset outside local mode");
  AST_UNMAPPED: assert property (par_rd && par_addr == 16'h0001 |=> par_err && par_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind drive_homing_io drive_homing_io_properties u_drive_homing_io_properties (
  .clk_sys(clk_sys), .reset_n(reset_n), .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr),
  .par_rd(par_rd), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
  .motor_standstill(motor_standstill), .step_pulse(step_pulse), .homing_success(homing_success),
  .current_position(current_position), .homing_cancel(homing_cancel),
  .search_error(search_error), .local_mode(local_mode), .fault_present(fault_present),
  .power_stage_on(power_stage_on), .fault_reset_req(fault_reset_req), .digital_out(digital_out)
);

/* File: testbench/fieldbus_master.sv */
`timescale 1ns/1ps

module fieldbus_master (
  // clock and answer
  input  logic        clk_sys,
  input  logic        par_ack,
  input  logic        par_err,
  input  logic [31:0] par_rdata,
  // request
  output logic [15:0] par_addr,
  output logic [31:0] par_wdata,
  output logic        par_wr,
  output logic        par_rd
);
  int timeouts;

  initial begin
    par_addr = 16'h0000;
    par_wdata = 32'h0;
    par_wr = 1'b0;
    par_rd = 1'b0;
  end

  // strobe lasts one cycle; released lines show the inverse so stale data never passes as valid
  task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    par_wr <= wr;
    par_rd <= !wr;
    par_addr <= a;
    par_wdata <= d;
    @(posedge clk_sys);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    par_addr <= ~a;
    par_wdata <= ~d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (par_ack !== 1'b1 && n < 4);
    if (par_ack !== 1'b1)
      timeouts++;
    rd = par_rdata;
    e = par_err;
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "drive_homing_consts.vh"

module testbench;
  typedef struct packed {logic w; logic [15:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
  logic        clk_sys, reset_n, par_wr, par_rd, par_ack, par_err, motor_standstill, motor_start, step_pulse;
  logic        step_dir_neg, homing_success, overtravel_seen, switch_seen_again, homing_cancel, search_error;
  logic        local_mode, fault_present, drive_ready, stage_disable_req, power_stage_on, io_in, halt_req;
  logic        io_out, io_oe_n;
  logic [15:0] par_addr, digital_out;
  logic [31:0] par_wdata, par_rdata, current_position, rd;
  logic        er;
  int          mismatches, comparisons, cycles, n;
  row_t        rows [0:21];

  drive_homing_io u_drive_homing_io (.clk_sys(clk_sys), .reset_n(reset_n), .par_addr(par_addr),
    .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd), .par_rdata(par_rdata), .par_ack(par_ack),
    .par_err(par_err), .motor_standstill(motor_standstill), .motor_start(motor_start), .step_pulse(step_pulse),
    .step_dir_neg(step_dir_neg), .homing_success(homing_success), .overtravel_seen(overtravel_seen),
    .switch_seen_again(switch_seen_again), .current_position(current_position), .homing_cancel(homing_cancel),
    .search_error(search_error), .local_mode(local_mode), .fault_present(fault_present),
    .drive_ready(drive_ready), .stage_disable_req(stage_disable_req), .power_stage_on(power_stage_on),
    .configurable_io_one_in(io_in), .configurable_io_one_out(io_out), .configurable_io_one_oe_n(io_oe_n),
    .fault_reset_req(), .halt_req(halt_req), .jog_pos(), .jog_neg(), .jog_fast(), .ref_switch(),
    .positive_travel_limit(), .digital_out(digital_out));
  fieldbus_master u_fieldbus_master (.clk_sys(clk_sys), .par_ack(par_ack), .par_err(par_err),
    .par_rdata(par_rdata), .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    u_fieldbus_master.access(1'b1, a, d, rd, er);
  endtask

  task automatic power_cycle;
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(8);
  endtask

  task automatic complete_run;
    mismatches += u_fieldbus_master.timeouts;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    {reset_n, motor_start, step_pulse, step_dir_neg, homing_success, overtravel_seen, io_in} = 7'h0;
    {switch_seen_again, local_mode, fault_present, drive_ready, stage_disable_req} = 5'h0;
    motor_standstill = 1'b1;
    rows = '{'{0, `ADDR_POWER_ON_POLICY, 0, 0, 0}, '{0, `ADDR_IO_CHANNEL1_FUNC, 0, 1, 0},
      '{0, `ADDR_DIRECT_OUTPUT, 0, 0, 0}, '{0, `ADDR_HOME_POSITION, 0, 0, 0}, '{0, `ADDR_SEARCH_LIMIT, 0, 0, 0},
      '{1, `ADDR_DIRECT_OUTPUT, 32'h5a5, 32'h5a5, 0}, '{1, `ADDR_HOME_POSITION, 32'h1234, 32'h1234, 0},
      '{1, `ADDR_SEARCH_LIMIT, 3, 3, 0}, '{1, 16'h0001, 5, 0, 1}, '{1, `ADDR_CURRENT_POSITION, 5, 0, 1},
      '{1, 16'h0722, 1, 1, 0}, '{1, 16'h0722, 2, 2, 0}, '{1, 16'h0722, 3, 3, 0}, '{1, 16'h0722, 9, 9, 0},
      '{1, 16'h0722, 10, 10, 0}, '{1, 16'h0722, 11, 11, 0}, '{1, 16'h0722, 20, 20, 0},
      '{1, 16'h0722, 21, 21, 0}, '{1, 16'h0722, 101, 101, 0}, '{1, 16'h0722, 102, 102, 0},
      '{1, 16'h0722, 103, 103, 0}, '{1, 16'h0722, 4, 4, 0}};
    tick(6);
    reset_n <= 1'b1;
    // --------------------------------
    // register table and function codes
    // --------------------------------
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        check("write error", 32'(er), 32'(rows[i].e));
      end
      u_fieldbus_master.access(1'b0, rows[i].a, 32'h0, rd, er);
      check("read data", rd, rows[i].r);
    end
    check("digital outputs", {16'h0, digital_out}, 32'h5a5);
    // --------------------------------
    // hand-written cases
    // --------------------------------
    io_in <= 1'b1;
    tick(6);
    check("halt before power-on", 32'(halt_req), 0);
    wr(`ADDR_POSITION_SET, 32'h8000_0005);
    tick(1);
    check("position set", current_position, 32'h8000_0005);
    motor_standstill <= 1'b0;
    wr(`ADDR_POSITION_SET, 32'h7);
    tick(1);
    check("set while moving", current_position, 32'h8000_0005);
    motor_standstill <= 1'b1;
    motor_start <= 1'b1;
    tick(1);
    motor_start <= 1'b0;
    wr(`ADDR_HOME_POSITION, 32'h77);
    for (n = 0; n < 2; n++) begin
      homing_success <= 1'b1;
      tick(1);
      homing_success <= 1'b0;
      tick(1);
      check("home position", current_position, 32'h1234);
    end
    // limit of three is active, then zero disables the monitor
    for (n = 0; n < 2; n++) begin
      motor_start <= 1'b1;
      tick(1);
      motor_start <= 1'b0;
      overtravel_seen <= 1'b1;
      tick(1);
      overtravel_seen <= 1'b0;
      step_pulse <= 1'b1;
      step_dir_neg <= n[0];
      tick(n == 0 ? 3 : 6);
      step_pulse <= 1'b0;
      if (n == 0) begin
        for (int k = 0; k < 10 && homing_cancel !== 1'b1; k++) tick(1);
        check("homing cancel", 32'(homing_cancel), 1);
        tick(2);
        check("search error", 32'(search_error), 1);
        wr(`ADDR_STATUS, 32'h2);
        wr(`ADDR_SEARCH_LIMIT, 32'h0);
      end else begin
        tick(4);
        check("monitor off", 32'(search_error), 0);
      end
    end
    check("stage off", 32'(power_stage_on), 0);
    wr(`ADDR_POWER_ON_POLICY, 32'h2);
    for (int k = 0; k < 10 && power_stage_on !== 1'b1; k++) tick(1);
    check("automatic enable", 32'(power_stage_on), 1);
    wr(`ADDR_IO_CHANNEL1_FUNC, 32'h1);
    check("refused io write", 32'(er), 1);
    u_fieldbus_master.access(1'b0, `ADDR_IO_CHANNEL1_FUNC, 32'h0, rd, er);
    check("io function kept", rd, 32'h4);
    wr(`ADDR_POWER_ON_POLICY, 32'h0);
    check("stage still on", 32'(power_stage_on), 1);
    fault_present <= 1'b1;
    tick(2);
    fault_present <= 1'b0;
    tick(8);
    check("edge policy after fault", 32'(power_stage_on), 0);
    // --------------------------------
    // mid-run resets stand for power-on of the io function
    // --------------------------------
    power_cycle;
    check("halt after power-on", 32'(halt_req), 1);
    check("outputs after reset", {16'h0, digital_out}, 32'h0);
    wr(`ADDR_IO_CHANNEL1_FUNC, 32'h67);
    check("io write with stage off", 32'(er), 0);
    drive_ready <= 1'b1;
    power_cycle;
    check("ready output enable", 32'(io_oe_n), 0);
    check("ready output", 32'(io_out), 1);
    wr(`ADDR_IO_CHANNEL1_FUNC, 32'h3);
    io_in <= 1'b0;
    local_mode <= 1'b1;
    power_cycle;
    check("no enable edge", 32'(power_stage_on), 0);
    io_in <= 1'b1;
    tick(8);
    check("enable on rising edge", 32'(power_stage_on), 1);
    complete_run;
  end
endmodule
